// File: verilog/sirq_pkg.sv
// Package for the serial interrupt request block.
// Assumes Avalon-MM with 32-bit data and one register per aligned word.
package sirq_pkg;
	// Register indices as printed; byte address is four times the index
	localparam logic [9:0] IDX_CH1_COL  = 10'h046;
	localparam logic [9:0] IDX_CH0_COL  = 10'h047;
	localparam logic [9:0] IDX_CH2_COL  = 10'h04a;
	localparam logic [9:0] IDX_CH2_TX   = 10'h04f;
	localparam logic [9:0] IDX_CH2_RX   = 10'h050;
	localparam logic [9:0] IDX_CH0_TX   = 10'h051;
	localparam logic [9:0] IDX_CH0_RX   = 10'h052;
	localparam logic [9:0] IDX_CH1_TX   = 10'h053;
	localparam logic [9:0] IDX_CH1_RX   = 10'h054;
	localparam logic [9:0] IDX_CH5_COL  = 10'h06b;
	localparam logic [9:0] IDX_CH5_TX   = 10'h06c;
	localparam logic [9:0] IDX_CH5_RX   = 10'h06d;
	localparam logic [9:0] IDX_CH6_COL  = 10'h06e;
	localparam logic [9:0] IDX_CH6_TX   = 10'h06f;
	localparam logic [9:0] IDX_CH6_RX   = 10'h070;
	localparam logic [9:0] IDX_CH7_COL  = 10'h071;
	localparam logic [9:0] IDX_CH7_TX   = 10'h072;
	localparam logic [9:0] IDX_CH7_RX   = 10'h073;
	localparam logic [9:0] IDX_SRCSEL3  = 10'h205;
	localparam logic [9:0] IDX_SRCSEL2  = 10'h206;
	// Own registers: serial mode per channel, cutoff enable, status group
	localparam logic [9:0] IDX_MODE_CH0 = 10'h300;
	localparam logic [9:0] IDX_CUTOFF   = 10'h306;
	localparam logic [9:0] IDX_STATUS   = 10'h307;
	localparam logic [9:0] IDX_IRQ_EN   = 10'h308;
	localparam logic [9:0] IDX_IRQ_CLR  = 10'h309;
	localparam int         NUM_CH       = 6;
	localparam int         NUM_REQ      = 18;
	// Request-control field layout: bits 2..0 reset to zero, bit 3 = flag
	localparam int         REQ_FLAG_BIT = 3;
	localparam logic [2:0] REQ_LOW_RST  = 3'h0;
	localparam logic [7:0] SRCSEL_RST   = 8'h00;
	// Source select bit positions
	localparam int         SEL2_CH7_DET = 4;
	localparam int         SEL2_CH7_TXN = 5;
	localparam int         SEL2_CH0_DET = 6;
	localparam int         SEL2_CH1_DET = 7;
	localparam int         SEL3_CH5_DET = 3;
	localparam int         SEL3_CH5_TXN = 4;
	localparam int         SEL3_CH6_DET = 5;
	localparam int         SEL3_CH6_TXN = 6;
	// Mode register fields: [2:0] mode, 3 twowire, 4 twowire2, 5 phase,
	// 6 ch2 tx source select, 7 ch2 error signal enable
	localparam logic [2:0] MODE_TWO_WIRE = 3'h2;
	localparam int         MODE_TW_BIT   = 3;
	localparam int         MODE_TW2_BIT  = 4;
	localparam int         MODE_PH_BIT   = 5;
	localparam int         MODE_TXS_BIT  = 6;
	localparam int         MODE_ERE_BIT  = 7;
	// Status bits: per channel rx overrun event
	localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;
endpackage

// File: verilog/serial_irq_logic.sv
// Interrupt request flags and routing for six serial channels.
// Assumes channel events arrive as synchronous pulses/levels on I_CORE_CLK.
`timescale 1ns/100ps
module serial_irq_logic
	import sirq_pkg::*;
(
	// Clock and reset
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_SRST,
	// Avalon-MM slave
	input  wire logic [11:0] I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	input  wire logic [3:0]  I_AVS_BYTEENABLE,
	output logic [31:0]      O_AVS_READDATA,
	output logic             O_AVS_WAITREQUEST,
	// Channel events, one bit per channel 0,1,2,5,6,7
	input  wire logic [5:0]  I_TX_EVT,
	input  wire logic [5:0]  I_DETECT_EVT,
	input  wire logic [5:0]  I_RX_LOAD,
	input  wire logic [5:0]  I_RX_READ,
	// Vector acknowledge, one bit per request flag
	input  wire logic [17:0] I_VEC_ACK,
	// Shutdown input and pins subject to cutoff
	input  wire logic        I_SHUTDOWN_N,
	input  wire logic [5:0]  I_PIN_OUT,
	input  wire logic [5:0]  I_PIN_OE,
	output logic [5:0]       O_PIN_OUT,
	output logic [5:0]       O_PIN_OE,
	// Request flags to the processor controller and block interrupt
	output logic [17:0]      O_REQ_FLAG,
	output logic [5:0]       O_OVERRUN,
	output logic             O_IRQ
);

	// Flag index: 0..5 tx, 6..11 rx, 12..17 detect (channel order 0,1,2,5,6,7)
	typedef struct packed {
		logic [17:0]      flag;
		logic [17:0][2:0] low;
		logic [7:0]       sel2;
		logic [7:0]       sel3;
		logic [5:0][7:0]  mode;
		logic [5:0]       rxc;
		logic [5:0]       ovr;
		logic             cutoff;
		logic [5:0]       sts;
		logic [5:0]       en;
		logic             ch2_arm;
		logic [31:0]      rdata;
		logic             ack;
	} state_type;

	// Register map seen by software, by word index:
	//   request control, one per flag slot:
	//     bits 2..0 stored as written, bit 3 the request flag,
	//     upper bits read as zero
	//   tx slots 0..5, rx slots 6..11, detect slots 12..17
	//   channel order inside each group is 0,1,2,5,6,7
	//   source select two and three: eight plain bits each
	//   mode registers, one per channel, in the 0x300 group:
	//     bits 2..0 serial mode field
	//     bit 3 two-wire enable, bit 4 second two-wire enable
	//     bit 5 clock phase
	//     bits 6,7 ch2 transmit source and error enable
	//   cutoff enable: bit 0 only
	//   overrun status: read only, sticky per channel
	//   status enable: gates the block interrupt
	//   status clear: write ones to clear, reads as zero
	// Limitation: the mode copies here only drive request side
	// effects; the serial channels keep their own mode state.
	// Trade-off: every register is one word so the bus decode stays
	// a single compare on the word index.

	state_type cur_ff;
	state_type nxt_ff;

	// Map printed index to request slot; -1 when not a request register
	function automatic int slot_of(input logic [9:0] idx);
		case (idx)
			IDX_CH0_TX:  slot_of = 0;
			IDX_CH1_TX:  slot_of = 1;
			IDX_CH2_TX:  slot_of = 2;
			IDX_CH5_TX:  slot_of = 3;
			IDX_CH6_TX:  slot_of = 4;
			IDX_CH7_TX:  slot_of = 5;
			IDX_CH0_RX:  slot_of = 6;
			IDX_CH1_RX:  slot_of = 7;
			IDX_CH2_RX:  slot_of = 8;
			IDX_CH5_RX:  slot_of = 9;
			IDX_CH6_RX:  slot_of = 10;
			IDX_CH7_RX:  slot_of = 11;
			IDX_CH0_COL: slot_of = 12;
			IDX_CH1_COL: slot_of = 13;
			IDX_CH2_COL: slot_of = 14;
			IDX_CH5_COL: slot_of = 15;
			IDX_CH6_COL: slot_of = 16;
			IDX_CH7_COL: slot_of = 17;
			default:     slot_of = -1;
		endcase
	endfunction

	logic [9:0]  idx;
	logic        acc;
	logic [17:0] hw_set;
	logic [5:0]  ovr_evt;
	logic [5:0]  route_det;
	logic [5:0]  route_tx;
	logic        cut;

	assign idx = I_AVS_ADDRESS[11:2];
	// One wait cycle: request answered on the edge after it is seen
	assign acc = (I_AVS_READ || I_AVS_WRITE) && !cur_ff.ack;

	// Routing enables for the shared vectors
	always_comb begin
		route_det    = 6'h3f;
		route_tx     = 6'h3f;
		route_det[0] = cur_ff.sel2[SEL2_CH0_DET];
		route_det[1] = cur_ff.sel2[SEL2_CH1_DET];
		route_det[3] = !cur_ff.sel3[SEL3_CH5_DET];
		route_tx[3]  = !cur_ff.sel3[SEL3_CH5_TXN];
		route_det[4] = !cur_ff.sel3[SEL3_CH6_DET];
		route_tx[4]  = !cur_ff.sel3[SEL3_CH6_TXN];
		route_det[5] = !cur_ff.sel2[SEL2_CH7_DET];
		route_tx[5]  = !cur_ff.sel2[SEL2_CH7_TXN];
	end

	// Next-state logic: bus, flags, receive tracking
	always_comb begin
		int s;
		logic tw;
		logic ch2_both;
		s        = slot_of(idx);
		tw       = 1'b0;
		ch2_both = 1'b0;
		nxt_ff   = cur_ff;
		hw_set   = 18'h0;
		ovr_evt  = 6'h0;
		nxt_ff.ack = acc;
		for (int c = 0; c < NUM_CH; c++) begin
			tw = (cur_ff.mode[c][2:0] == MODE_TWO_WIRE);
			// Receive-complete flag follows load and read
			if (I_RX_LOAD[c]) begin
				nxt_ff.rxc[c] = 1'b1;
				if (cur_ff.rxc[c]) begin
					nxt_ff.ovr[c] = 1'b1;
					ovr_evt[c]    = 1'b1;
				end
			end else if (I_RX_READ[c]) begin
				nxt_ff.rxc[c] = 1'b0;
				nxt_ff.ovr[c] = 1'b0;
			end
			// Rising edge only; overrun adds a set just in two-wire mode
			hw_set[6+c] = (I_RX_LOAD[c] && !cur_ff.rxc[c])
				|| (tw && ovr_evt[c]);
			hw_set[c]    = I_TX_EVT[c] && route_tx[c];
			hw_set[12+c] = I_DETECT_EVT[c] && route_det[c];
		end
		// Spurious request when a mode write changes bits 5..0 while in two-wire mode
		if (acc && I_AVS_WRITE && I_AVS_BYTEENABLE[0]
			&& idx >= IDX_MODE_CH0 && idx < IDX_CUTOFF) begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (idx == IDX_MODE_CH0 + 10'(c)) begin
					nxt_ff.mode[c] = I_AVS_WRITEDATA[7:0];
					if (cur_ff.mode[c][2:0] == MODE_TWO_WIRE
						&& (I_AVS_WRITEDATA[5:0] != cur_ff.mode[c][5:0]))
						hw_set[6+c] = 1'b1;
				end
			end
		end
		// Ch2 transmit request once both bits reach one after reset
		ch2_both = nxt_ff.mode[2][MODE_TXS_BIT]
			&& nxt_ff.mode[2][MODE_ERE_BIT];
		if (ch2_both && !cur_ff.ch2_arm) begin
			hw_set[2]      = 1'b1;
			nxt_ff.ch2_arm = 1'b1;
		end
		// Acknowledges clear, software writes load bit 3, hardware set wins
		for (int k = 0; k < NUM_REQ; k++) begin
			if (I_VEC_ACK[k])
				nxt_ff.flag[k] = 1'b0;
		end
		if (acc && I_AVS_WRITE && I_AVS_BYTEENABLE[0] && s >= 0) begin
			nxt_ff.flag[s] = I_AVS_WRITEDATA[REQ_FLAG_BIT];
			nxt_ff.low[s]  = I_AVS_WRITEDATA[2:0];
		end
		nxt_ff.flag = nxt_ff.flag | hw_set;
		// Other register writes
		if (acc && I_AVS_WRITE && I_AVS_BYTEENABLE[0]) begin
			case (idx)
				IDX_SRCSEL2: nxt_ff.sel2   = I_AVS_WRITEDATA[7:0];
				IDX_SRCSEL3: nxt_ff.sel3   = I_AVS_WRITEDATA[7:0];
				IDX_CUTOFF:  nxt_ff.cutoff = I_AVS_WRITEDATA[0];
				IDX_IRQ_EN:  nxt_ff.en     = I_AVS_WRITEDATA[5:0];
				default:     nxt_ff.en     = nxt_ff.en;
			endcase
		end
		// Overrun status: clear by write, new event wins
		if (acc && I_AVS_WRITE && I_AVS_BYTEENABLE[0]
			&& idx == IDX_IRQ_CLR)
			nxt_ff.sts = cur_ff.sts & ~I_AVS_WRITEDATA[5:0];
		nxt_ff.sts = nxt_ff.sts | ovr_evt;
		// Read data
		nxt_ff.rdata = UNMAPPED_RD;
		if (acc && I_AVS_READ) begin
			if (s >= 0)
				nxt_ff.rdata = {28'h0, cur_ff.flag[s], cur_ff.low[s]};
			else begin
				case (idx)
					IDX_SRCSEL2: nxt_ff.rdata = {24'h0, cur_ff.sel2};
					IDX_SRCSEL3: nxt_ff.rdata = {24'h0, cur_ff.sel3};
					IDX_CUTOFF:  nxt_ff.rdata = {31'h0, cur_ff.cutoff};
					IDX_STATUS:  nxt_ff.rdata = {26'h0, cur_ff.sts};
					IDX_IRQ_EN:  nxt_ff.rdata = {26'h0, cur_ff.en};
					default: begin
						if (idx >= IDX_MODE_CH0 && idx < IDX_CUTOFF)
							nxt_ff.rdata = {24'h0,
								cur_ff.mode[3'(idx - IDX_MODE_CH0)]};
					end
				endcase
			end
		end
	end

	// State register; unknown upper bits are kept as zero after reset
	always_ff @(posedge I_CORE_CLK) begin
		if (I_SRST) begin
			cur_ff      <= '0;
			cur_ff.sel2 <= SRCSEL_RST;
			cur_ff.sel3 <= SRCSEL_RST;
			cur_ff.low  <= {NUM_REQ{REQ_LOW_RST}};
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// Forced cutoff of the shared pins
	assign cut       = cur_ff.cutoff && !I_SHUTDOWN_N;
	assign O_PIN_OUT = cut ? 6'h0 : I_PIN_OUT;
	assign O_PIN_OE  = cut ? 6'h0 : I_PIN_OE;

	// Outputs
	assign O_AVS_READDATA    = cur_ff.rdata;
	assign O_AVS_WAITREQUEST = (I_AVS_READ || I_AVS_WRITE) && !cur_ff.ack;
	assign O_REQ_FLAG        = cur_ff.flag;
	assign O_OVERRUN         = cur_ff.ovr;
	assign O_IRQ             = |(cur_ff.sts & cur_ff.en);

endmodule

// File: testbench/serial_irq_logic_sva.sv
// Checker for the serial interrupt request block.
// Assumes it is bound to serial_irq_logic and sees its ports only.
`timescale 1ns/100ps
module sirq_sva (
	input wire logic        I_CORE_CLK,
	input wire logic        I_SRST,
	input wire logic        I_AVS_READ,
	input wire logic        I_AVS_WRITE,
	input wire logic        O_AVS_WAITREQUEST,
	input wire logic [5:0]  I_TX_EVT,
	input wire logic [5:0]  I_DETECT_EVT,
	input wire logic [5:0]  I_RX_LOAD,
	input wire logic [5:0]  I_RX_READ,
	input wire logic [17:0] I_VEC_ACK,
	input wire logic        I_SHUTDOWN_N,
	input wire logic [5:0]  I_PIN_OE,
	input wire logic [5:0]  O_PIN_OE,
	input wire logic [17:0] O_REQ_FLAG,
	input wire logic [5:0]  O_OVERRUN
);
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_SRST);
	// Buffer emptied, then refilled: a fresh rising receive-complete
	sequence s_refill;
		I_RX_READ[0] ##1 (I_RX_LOAD[0] && !I_RX_READ[0]);
	endsequence
	// Two loads with no read between always overrun
	sequence s_twice;
		(I_RX_LOAD[0] && !I_RX_READ[0]) ##1 (I_RX_LOAD[0] && !I_RX_READ[0]);
	endsequence
	a_tx_sets_flag: assert property (I_TX_EVT[0] |=> O_REQ_FLAG[0])
		else $error("tx flag not set");
	a_det_sets_flag: assert property (I_DETECT_EVT[2] |=> O_REQ_FLAG[14])
		else $error("detect flag not set");
	a_flag_holds: assert property (O_REQ_FLAG[0] && !I_VEC_ACK[0]
		&& !I_AVS_WRITE |=> O_REQ_FLAG[0]) else $error("flag dropped");
	a_ack_clears: assert property (I_VEC_ACK[0] && !I_TX_EVT[0]
		&& !I_AVS_WRITE |=> !O_REQ_FLAG[0]) else $error("ack ignored");
	a_rx_refill: assert property (s_refill |=> O_REQ_FLAG[6])
		else $error("rx flag not set on refill");
	a_overrun_set: assert property (s_twice |=> O_OVERRUN[0])
		else $error("overrun not flagged");
	a_pin_pass: assert property (I_SHUTDOWN_N |-> O_PIN_OE == I_PIN_OE)
		else $error("pin enable gated without shutdown");
	a_wait_answer: assert property ((I_AVS_READ || I_AVS_WRITE)
		&& O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
		else $error("no bus answer");
	a_reset_clear: assert property (disable iff (1'b0) I_SRST
		|=> O_REQ_FLAG == 18'h0 && O_OVERRUN == 6'h0)
		else $error("flags not cleared by reset");
endmodule
bind serial_irq_logic sirq_sva chk (.I_CORE_CLK(I_CORE_CLK),
	.I_SRST(I_SRST), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
	.O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_TX_EVT(I_TX_EVT),
	.I_DETECT_EVT(I_DETECT_EVT), .I_RX_LOAD(I_RX_LOAD),
	.I_RX_READ(I_RX_READ), .I_VEC_ACK(I_VEC_ACK),
	.I_SHUTDOWN_N(I_SHUTDOWN_N), .I_PIN_OE(I_PIN_OE), .O_PIN_OE(O_PIN_OE),
	.O_REQ_FLAG(O_REQ_FLAG), .O_OVERRUN(O_OVERRUN));

// File: testbench/sirq_host_model.sv
// Host side: interrupt controller acknowledging pending vectors.
// Assumes flags are registered on the same clock as the block.
`timescale 1ns/100ps
module sirq_host_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ack_en,
	input  wire logic [3:0]  ack_delay,
	input  wire logic [17:0] req_flag,
	output logic      [17:0] vec_ack
);
	logic [3:0] wait_cnt;
	// Latency is programmable so both prompt and slow hosts are seen
	always_ff @(posedge clk) begin
		vec_ack <= 18'h0;
		if (rst || !ack_en || req_flag == 18'h0) begin
			wait_cnt <= 4'h0;
		end else if (wait_cnt >= ack_delay) begin
			vec_ack  <= req_flag;
			wait_cnt <= 4'h0;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule

// File: testbench/serial_irq_logic_tb_top.sv
// Self-checking bench for the serial interrupt request block.
// Assumes the checker is bound in and the host model acks flags.
`timescale 1ns/100ps
module serial_irq_logic_tb_top;
	import sirq_pkg::*;
	logic        clk, srst, rd, wr, waitreq, shut_n, irq, ack_en;
	logic [11:0] addr;
	logic [31:0] wdata, rdata;
	logic [5:0]  tx, det, rxl, rxr, pout, poe, ovr;
	logic [17:0] vack, flags;
	logic [3:0]  ack_dly;
	int          err_count, total_checks;
	serial_irq_logic dut (.I_CORE_CLK(clk), .I_SRST(srst),
		.I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
		.I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hf),
		.O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
		.I_TX_EVT(tx), .I_DETECT_EVT(det), .I_RX_LOAD(rxl),
		.I_RX_READ(rxr), .I_VEC_ACK(vack), .I_SHUTDOWN_N(shut_n),
		.I_PIN_OUT(6'h3f), .I_PIN_OE(6'h3f), .O_PIN_OUT(pout),
		.O_PIN_OE(poe), .O_REQ_FLAG(flags), .O_OVERRUN(ovr), .O_IRQ(irq));
	sirq_host_model host (.clk(clk), .rst(srst), .ack_en(ack_en),
		.ack_delay(ack_dly), .req_flag(flags), .vec_ack(vack));
	always #20 clk = ~clk;
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// One Avalon transfer; waits on waitrequest, bounded by the watchdog.
	// Inputs only move on the rising edge, so the mid-cycle look equals
	// what the slave shows at the following edge; release follows it.
	task automatic bus(input logic w, input logic [9:0] idx,
		input logic [7:0] d, output logic [31:0] q);
		logic busy;
		busy = 1'b1;
		q    = '0;
		@(posedge clk);
		addr <= {idx, 2'b00};
		rd <= !w;
		wr <= w;
		wdata <= {24'h0, d};
		while (busy) begin
			@(negedge clk);
			busy = (waitreq !== 1'b0);
			q    = rdata;
			@(posedge clk);
		end
		rd <= 1'b0;
		wr <= 1'b0;
		#1;
	endtask
	task automatic wr8(input logic [9:0] idx, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
	endtask
	task automatic rdchk(input string n, input logic [9:0] idx,
		input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, idx, 8'h00, q);
		check(n, q, {24'h0, e});
	endtask
	// Event pulse of one cycle; kind 0 tx, 1 detect, 2 load, 3 read
	task automatic pulse(input int kind, input logic [5:0] v);
		@(posedge clk);
		tx <= (kind == 0) ? v : 6'h0;
		det <= (kind == 1) ? v : 6'h0;
		rxl <= (kind == 2) ? v : 6'h0;
		rxr <= (kind == 3) ? v : 6'h0;
		@(posedge clk);
		{tx, det, rxl, rxr} <= 24'h0;
		#1;
	endtask
	task automatic clear_flags;
		@(posedge clk);
		ack_en <= 1'b1;
		@(negedge clk);
		while (flags !== 18'h0) @(negedge clk);
		@(posedge clk);
		ack_en <= 1'b0;
	endtask
	task automatic t_reset;
		rdchk("ch0 rx ctrl", IDX_CH0_RX, {5'h0, REQ_LOW_RST});
		rdchk("ch7 col ctrl", IDX_CH7_COL, {5'h0, REQ_LOW_RST});
		rdchk("select two", IDX_SRCSEL2, SRCSEL_RST);
		rdchk("select three", IDX_SRCSEL3, SRCSEL_RST);
		rdchk("unmapped", 10'h3ff, UNMAPPED_RD[7:0]);
		$display("test reset done");
	endtask
	task automatic t_route;
		pulse(1, 6'h3f);
		check("detect default", flags[17:12], 6'h3c);
		pulse(0, 6'h3f);
		check("tx default", flags[5:0], 6'h3f);
		clear_flags;
		wr8(IDX_SRCSEL2, 8'hf0);
		wr8(IDX_SRCSEL3, 8'h78);
		pulse(1, 6'h3f);
		check("detect swapped", flags[17:12], 6'h07);
		pulse(0, 6'h3f);
		check("tx swapped", flags[5:0], 6'h07);
		clear_flags;
		$display("test routing done");
	endtask
	task automatic t_rx;
		ack_dly <= 4'h3;
		pulse(2, 6'h01);
		check("rx flag", flags[6], 1'b1);
		clear_flags;
		pulse(2, 6'h01);
		check("rx flag overrun", flags[6], 1'b0);
		check("overrun", ovr[0], 1'b1);
		rdchk("status", IDX_STATUS, 8'h01);
		wr8(IDX_IRQ_EN, 8'h01);
		check("irq raised", irq, 1'b1);
		wr8(IDX_IRQ_CLR, 8'h01);
		check("irq cleared", irq, 1'b0);
		pulse(3, 6'h01);
		wr8(IDX_MODE_CH0, {5'h0, MODE_TWO_WIRE});
		clear_flags;
		pulse(2, 6'h01);
		check("two-wire rx flag", flags[6], 1'b1);
		clear_flags;
		pulse(2, 6'h01);
		check("two-wire overrun flag", flags[6], 1'b1);
		clear_flags;
		wr8(IDX_MODE_CH0, 8'h22);
		check("spurious flag", flags[6], 1'b1);
		clear_flags;
		$display("test receive done");
	endtask
	task automatic t_sim_cut;
		wr8(IDX_MODE_CH0 + 10'h2, 8'hc0);
		check("ch2 tx flag", flags[2], 1'b1);
		wr8(IDX_CH2_TX, 8'h00);
		check("ch2 tx cleared", flags[2], 1'b0);
		@(posedge clk);
		shut_n <= 1'b0;
		#1;
		check("oe no cutoff", poe, 6'h3f);
		wr8(IDX_CUTOFF, 8'h01);
		check("oe cutoff", poe, 6'h00);
		check("out cutoff", pout, 6'h00);
		$display("test smart-card and cutoff done");
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Whole run is about a hundred cycles; this is a generous margin
	initial begin
		#100us;
		err_count++;
		summarize;
	end
	initial begin
		{clk, rd, wr, ack_en, addr, wdata} = '0;
		{tx, det, rxl, rxr} = 24'h0;
		{srst, shut_n, ack_dly} = {2'b11, 4'h1};
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_reset;
		t_route;
		t_rx;
		t_sim_cut;
		summarize;
	end
endmodule
